// ==== design/eeprom_port.sv ====
// Serial command port of a 256 x 16 nonvolatile word memory.

// Functional notes
// - Ignore input until first one after select
// - Two-bit code selects read, write, erase, special
// - Special code: top address bits pick command
// - Read shifts out addressed 16-bit word
// - Dummy zero driven on last address edge
// - Continued clocking streams next higher words
// - Writes take 16 bits MSB first, erase-before-write
// - Single erase and bulk clear are optional
// - Input sampled on serial clock rise
// - Read output changes on serial clock rise
// - Status shown after write until start bit
// - Reset clears the write-enable latch
// - Latch stays set until lock command
// - Reads work whether locked or unlocked
// - Status low while busy, high when ready
// - Programming starts on select fall after command
// - Locked device ignores write-type commands
// - No command but read accepted while busy
module eeprom_port
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Serial link pins
  input wire logic chip_select_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  // Serial output pin, split into level and enable
  output logic serial_out_pin,
  output logic serial_out_oe
);

  // ----------------------------------------------------------------
  // Link domain: command shifter on the serial clock
  // ----------------------------------------------------------------

  // Sequencer states of one command frame.
  typedef enum {L_START, L_OP, L_ADDR, L_DATA, L_READ, L_DONE} link_e;

  link_e lstate_reg, lstate_next; // Frame sequencer.
  logic [3:0] lcnt_reg, lcnt_next; // Bit index within a field.
  link_flags_s lflag_reg, lflag_next; // Flags seen by the core.
  logic [DATA_W-1:0] shift_reg, shift_next; // Incoming bit history.
  logic [1:0] op_reg, op_next; // Captured operating code.
  cmd_s cmd_reg, cmd_next; // Command for the core.
  logic [ADDR_W-1:0] raddr_reg, raddr_next; // Read word address.
  logic [DATA_W-1:0] rdsh_reg, rdsh_next; // Read data shifter.
  logic [DATA_W-1:0] rd_word; // Word latched from the array.
  logic [ADDR_W-1:0] full_addr; // Address including this edge.

  // Next-state logic of the frame sequencer.
  always_comb begin
    lstate_next = lstate_reg;
    lcnt_next = lcnt_reg;
    lflag_next = lflag_reg;
    shift_next = {shift_reg[DATA_W-2:0], serial_in_pin};
    op_next = op_reg;
    cmd_next = cmd_reg;
    raddr_next = raddr_reg;
    rdsh_next = rdsh_reg;
    full_addr = {shift_reg[ADDR_W-2:0], serial_in_pin};
    case (lstate_reg)
      // Zeros before the start bit are dropped.
      L_START: begin
        if (serial_in_pin) begin
          lstate_next = L_OP;
          lcnt_next = 4'h0;
          lflag_next.start_seen = 1'b1;
        end
      end
      // Two code bits follow the start bit.
      L_OP: begin
        lcnt_next = lcnt_reg + 4'h1;
        if (lcnt_reg == OP_LAST) begin
          op_next = {shift_reg[0], serial_in_pin};
          lstate_next = L_ADDR;
          lcnt_next = 4'h0;
        end
      end
      // Eight address bits, then branch on the code.
      L_ADDR: begin
        lcnt_next = lcnt_reg + 4'h1;
        if (lcnt_reg == ADDR_LAST) begin
          cmd_next.addr = full_addr;
          raddr_next = full_addr;
          lcnt_next = 4'h0;
          lstate_next = L_DONE;
          cmd_next.kind = CMD_NONE;
          case (op_reg)
            // Reads need no unlock; dummy zero goes out now.
            OP_READ: begin
              lstate_next = L_READ;
              lflag_next.rd_oe = 1'b1;
              lflag_next.rd_bit = 1'b0;
            end
            OP_WRITE: begin
              cmd_next.kind = CMD_WRITE;
              lstate_next = L_DATA;
            end
            OP_SPECIAL: begin
              cmd_next.kind = special_kind(full_addr[7:6]);
              if (special_kind(full_addr[7:6]) == CMD_FILL) begin
                lstate_next = L_DATA;
              end else if (special_kind(full_addr[7:6]) != CMD_NONE) begin
                lflag_next.cmd_done = 1'b1;
              end
            end
            // Optional erase codes are taken as no operation.
            default: begin
              lstate_next = L_DONE;
            end
          endcase
        end
      end
      // Sixteen data bits, most significant first.
      L_DATA: begin
        lcnt_next = lcnt_reg + 4'h1;
        if (lcnt_reg == DATA_LAST) begin
          cmd_next.data = {shift_reg[DATA_W-2:0], serial_in_pin};
          lflag_next.cmd_done = 1'b1;
          lstate_next = L_DONE;
        end
      end
      // Stream words; the address steps after each last bit.
      L_READ: begin
        if (lcnt_reg == 4'h0) begin
          lflag_next.rd_bit = rd_word[DATA_W-1];
          rdsh_next = {rd_word[DATA_W-2:0], 1'b0};
        end else begin
          lflag_next.rd_bit = rdsh_reg[DATA_W-1];
          rdsh_next = {rdsh_reg[DATA_W-2:0], 1'b0};
        end
        lcnt_next = lcnt_reg + 4'h1;
        if (lcnt_reg == DATA_LAST) begin
          raddr_next = raddr_reg + 8'h01;
        end
      end
      // Extra clocks after a finished command are ignored.
      L_DONE: begin
        lstate_next = L_DONE;
      end
      default: begin
        lstate_next = L_START;
      end
    endcase
  end

  // Frame control; select low clears it at once, without a clock.
  always_ff @(posedge serial_clock_pin or negedge chip_select_pin) begin
    if (!chip_select_pin) begin
      lstate_reg <= L_START;
      lcnt_reg <= 4'h0;
      lflag_reg <= '0;
    end else begin
      lstate_reg <= lstate_next;
      lcnt_reg <= lcnt_next;
      lflag_reg <= lflag_next;
    end
  end

  // Payload keeps its value past select low for the core to use.
  always_ff @(posedge serial_clock_pin) begin
    shift_reg <= shift_next;
    op_reg <= op_next;
    cmd_reg <= cmd_next;
    raddr_reg <= raddr_next;
    rdsh_reg <= rdsh_next;
  end

  // ----------------------------------------------------------------
  // Core domain: synchronisers and the write sequencer
  // ----------------------------------------------------------------

  // Write sequencer states.
  typedef enum {C_IDLE, C_FILL, C_WAIT} core_e;

  logic [4:0] meta_reg; // First synchroniser stage.
  logic [4:0] sync_reg; // Second stage, the only one read.
  logic cs_prev_reg; // Select level one cycle back.
  logic done_prev_reg; // Command-done level one cycle back.
  logic start_prev_reg; // Start level one cycle back.
  core_e cstate_reg, cstate_next; // Write sequencer.
  logic [TIMER_W-1:0] timer_reg, timer_next; // Write-time counter.
  logic [ADDR_W-1:0] fill_reg, fill_next; // Fill address.
  logic wel_reg, wel_next; // Write-enable latch.
  logic pend_reg, pend_next; // Complete command waits for select fall.
  logic stat_reg, stat_next; // Status display enabled.
  logic dout_reg, dout_next; // Output pin level.
  logic doe_reg, doe_next; // Output pin enable.
  logic wr_en; // Array write strobe.
  logic [ADDR_W-1:0] wr_addr; // Array write address.
  logic cs_s; // Synchronised select.
  link_flags_s fl; // Synchronised link flags.
  logic busy; // A write is in progress.

  // Two flip-flops on select and the link flags; the command payload from the link is used without them.
  always_ff @(posedge core_clk) begin
    meta_reg <= {chip_select_pin, lflag_reg};
    sync_reg <= meta_reg;
    cs_prev_reg <= sync_reg[4];
    done_prev_reg <= sync_reg[2];
    start_prev_reg <= sync_reg[3];
  end

  // Write timing, latch and output selection.
  always_comb begin
    cs_s = sync_reg[4];
    fl = link_flags_s'(sync_reg[3:0]);
    cstate_next = cstate_reg;
    timer_next = timer_reg;
    fill_next = fill_reg;
    wel_next = wel_reg;
    pend_next = pend_reg;
    stat_next = stat_reg;
    wr_en = 1'b0;
    wr_addr = cmd_reg.addr;
    // A new start bit ends the status display.
    if (fl.start_seen && !start_prev_reg) begin
      stat_next = 1'b0;
    end
    // Each frame drops any command left pending.
    if (cs_s != cs_prev_reg) begin
      pend_next = 1'b0;
    end
    // A finished command is kept only while idle; set wins.
    if (fl.cmd_done && !done_prev_reg && cstate_reg == C_IDLE) begin
      pend_next = 1'b1;
    end
    case (cstate_reg)
      // Commands act when select falls.
      C_IDLE: begin
        if (cs_prev_reg && !cs_s && pend_reg) begin
          case (cmd_reg.kind)
            CMD_UNLOCK: wel_next = 1'b1;
            CMD_LOCK: wel_next = 1'b0;
            CMD_WRITE: begin
              if (wel_reg) begin
                wr_en = 1'b1;
                timer_next = TIMER_W'(WRITE_CYCLES - 1);
                cstate_next = C_WAIT;
                stat_next = 1'b1;
              end
            end
            CMD_FILL: begin
              if (wel_reg) begin
                fill_next = 8'h00;
                timer_next = TIMER_W'(WRITE_CYCLES - 1);
                cstate_next = C_FILL;
                stat_next = 1'b1;
              end
            end
            default: begin
              cstate_next = C_IDLE;
            end
          endcase
        end
      end
      // Every word is replaced with the fill data.
      C_FILL: begin
        wr_en = 1'b1;
        wr_addr = fill_reg;
        fill_next = fill_reg + 8'h01;
        if (timer_reg != '0) begin
          timer_next = timer_reg - TIMER_W'(1);
        end
        if (fill_reg == LAST_ADDR) begin
          cstate_next = C_WAIT;
        end
      end
      // Remaining write time runs out here.
      C_WAIT: begin
        if (timer_reg == '0) begin
          cstate_next = C_IDLE;
        end else begin
          timer_next = timer_reg - TIMER_W'(1);
        end
      end
      default: begin
        cstate_next = C_IDLE;
      end
    endcase
    busy = (cstate_reg != C_IDLE);
    // Output pin: read data, then status, else floating.
    dout_next = 1'b0;
    doe_next = 1'b0;
    if (!cs_s) begin
      doe_next = 1'b0;
    end else if (fl.rd_oe) begin
      doe_next = 1'b1;
      dout_next = fl.rd_bit;
    end else if (stat_reg) begin
      doe_next = 1'b1;
      dout_next = !busy;
    end
  end

  // Core registers with synchronous active-low reset.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cstate_reg <= C_IDLE;
      timer_reg <= '0;
      fill_reg <= 8'h00;
      wel_reg <= WEL_RESET;
      pend_reg <= 1'b0;
      stat_reg <= 1'b0;
      dout_reg <= 1'b0;
      doe_reg <= 1'b0;
    end else begin
      cstate_reg <= cstate_next;
      timer_reg <= timer_next;
      fill_reg <= fill_next;
      wel_reg <= wel_next;
      pend_reg <= pend_next;
      stat_reg <= stat_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
    end
  end

  // ----------------------------------------------------------------
  // Word array and outputs
  // ----------------------------------------------------------------

  // Writes on the core clock, reads on the link clock.
  eeprom_array u_array (
    .wr_clk(core_clk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(cmd_reg.data),
    .rd_clk(serial_clock_pin),
    .rd_addr(raddr_next),
    .rd_data(rd_word)
  );

  // Pin outputs come straight from flip-flops.
  assign serial_out_pin = dout_reg;
  assign serial_out_oe = doe_reg;

endmodule : eeprom_port

// ==== design/eeprom_pkg.sv ====
// Shared constants and types of the serial memory command port.
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int WORDS = 256;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 8'hFF;

  // ----------------------------------------------------------------
  // Operating codes and special sub-commands
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_LOCK = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_CLEAR = 2'h2;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;

  // ----------------------------------------------------------------
  // Bit counts of each command field (last index of the field)
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_LAST = 4'h1;
  localparam logic [3:0] ADDR_LAST = 4'h7;
  localparam logic [3:0] DATA_LAST = 4'hF;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic WEL_RESET = 1'b0;
  localparam int CORE_CLK_HZ = 100_000_000;
  localparam int WRITE_TIME_MS = 10;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_MS * (CORE_CLK_HZ / 1000);
  localparam int TIMER_W = 20;

  // Decoded command that the link hands to the core.
  typedef enum logic [2:0] {
    CMD_NONE, CMD_UNLOCK, CMD_LOCK, CMD_WRITE, CMD_FILL
  } cmd_kind_e;

  // Command payload, stable from the last link edge to the next frame.
  typedef struct packed {
    cmd_kind_e kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_s;

  // Level flags passed from the link domain to the core domain.
  typedef struct packed {
    logic start_seen;
    logic cmd_done;
    logic rd_oe;
    logic rd_bit;
  } link_flags_s;

  // Maps the top two address bits of a special command to its kind.
  function automatic cmd_kind_e special_kind(input logic [1:0] sel);
    case (sel)
      SUB_UNLOCK: special_kind = CMD_UNLOCK;
      SUB_FILL: special_kind = CMD_FILL;
      SUB_LOCK: special_kind = CMD_LOCK;
      default: special_kind = CMD_NONE;
    endcase
  endfunction : special_kind

endpackage : eeprom_pkg

// ==== design/eeprom_array.sv ====
// Word array with a core-clock write port and a link-clock read port.
module eeprom_array
  import eeprom_pkg::*;
(
  // Write port
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // Read port
  input wire logic rd_clk,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  // Storage cells; a write replaces the whole word in one step.
  logic [DATA_W-1:0] cells [WORDS];

  // Write port stores on the core clock.
  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end

  // Read data leaves through a register on the link clock.
  always_ff @(posedge rd_clk) begin
    rd_data <= cells[rd_addr];
  end

endmodule : eeprom_array

// ==== tb/eeprom_port_properties.sv ====
// Concurrent checks on the pins of the serial command port.
module eeprom_port_properties
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Serial link pins
  input wire logic chip_select_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  // Serial output pin and enable
  input wire logic serial_out_pin,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic started_reg; // A start bit was taken in this frame.
  int idx_reg; // Link rises since the start bit.
  logic [1:0] op_reg; // Operating code of this frame.
  int busy_cnt_reg; // Cycles the pin has shown busy.
  logic rd_frame; // Frame is a read past its code.
  logic wr_frame; // Frame is a write past its code.
  assign rd_frame = started_reg && op_reg == OP_READ && idx_reg >= 3;
  assign wr_frame = started_reg && op_reg == OP_WRITE && idx_reg >= 3;

  // Tracks the frame; select low clears it as it does the port.
  always_ff @(posedge serial_clock_pin or negedge chip_select_pin) begin
    if (!chip_select_pin) begin
      started_reg <= 1'b0;
      idx_reg <= 0;
      op_reg <= 2'h0;
    end else if (!started_reg) begin
      started_reg <= serial_in_pin;
      idx_reg <= serial_in_pin ? 1 : 0;
    end else begin
      if (idx_reg < 3) op_reg <= {op_reg[0], serial_in_pin};
      if (idx_reg < 1000) idx_reg <= idx_reg + 1;
    end
  end

  // Counts how long a low level is driven without a break.
  always_ff @(posedge core_clk) begin
    if (!nrst || !(serial_out_oe && !serial_out_pin)) busy_cnt_reg <= 0;
    else busy_cnt_reg <= busy_cnt_reg + 1;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_read_addr_quiet: assert property (@(posedge serial_clock_pin)
    disable iff (!chip_select_pin) rd_frame && idx_reg <= 10
    |-> !serial_out_oe) else $error("output driven during read address");
  a_read_dummy_zero: assert property (@(posedge serial_clock_pin)
    disable iff (!chip_select_pin) rd_frame && idx_reg == 11
    |-> serial_out_oe && !serial_out_pin) else $error("no dummy zero");
  a_read_stream_on: assert property (@(posedge serial_clock_pin)
    disable iff (!chip_select_pin) rd_frame && idx_reg >= 12
    |-> serial_out_oe) else $error("read stream not driven");
  a_write_frame_quiet: assert property (@(posedge serial_clock_pin)
    disable iff (!chip_select_pin) wr_frame |-> !serial_out_oe)
    else $error("status kept after start bit");
  a_select_low_float: assert property (@(posedge core_clk)
    disable iff (!nrst) !chip_select_pin [*6] |-> !serial_out_oe)
    else $error("output driven with select low");
  a_reset_exit_quiet: assert property (@(posedge core_clk)
    disable iff (!nrst) $rose(nrst) |-> !serial_out_oe)
    else $error("output driven at reset exit");
  a_oe_needs_select: assert property (@(posedge core_clk)
    disable iff (!nrst) $rose(serial_out_oe) |-> chip_select_pin)
    else $error("output enabled without select");
  a_busy_bounded: assert property (@(posedge core_clk)
    disable iff (!nrst) busy_cnt_reg <= WRITE_CYCLES + 16)
    else $error("busy lasts too long");

  // Main scenarios reached.
  c_read_dummy: cover property (@(posedge serial_clock_pin)
    rd_frame && idx_reg == 11);
  c_busy_seen: cover property (@(posedge core_clk) busy_cnt_reg == 50);
  c_ready_seen: cover property (@(posedge core_clk)
    $rose(serial_out_oe) && serial_out_pin);
endmodule : eeprom_port_properties

// ==== tb/host_link_model.sv ====
// Host model that frames commands on the three-wire link.
module host_link_model (
  // Link pins driven by the host
  output logic chip_select_pin,
  output logic serial_clock_pin,
  output logic serial_in_pin,
  // Resolved serial output of the device
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;
  // Select pulses once with the clock low, so that the link logic starts
  // from a cleared frame however the processes are ordered at time zero.
  initial begin
    chip_select_pin = 1'b1;
    serial_clock_pin = 1'b0;
    serial_in_pin = 1'b0;
    #1 chip_select_pin = 1'b0;
  end

  // Sends n bits MSB first; the clock stands still outside frames.
  task automatic xfer(input logic [63:0] bits, input int n,
                      output logic [63:0] got);
    got = '0;
    #3.3 chip_select_pin = 1'b1;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_pin = bits[i];
      #62.5 serial_clock_pin = 1'b1;
      #62.5 serial_clock_pin = 1'b0;
      got = {got[62:0], dout};
    end
    serial_in_pin = 1'b0;
    #50 chip_select_pin = 1'b0;
    #200;
  endtask : xfer

  // Raises select with the input low and samples the status level.
  task automatic poll(output logic s);
    #3.3 chip_select_pin = 1'b1;
    #200 s = dout;
    #20 chip_select_pin = 1'b0;
    #100;
  endtask : poll
endmodule : host_link_model

// ==== tb/test_serial_eeprom_command_port.sv ====
// Self-checking bench of the serial command port.
module test_serial_eeprom_command_port import eeprom_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WRITE_CYCLES = 1000; // Shortened write time.
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  wire cs_w, sk_w, di_w, out_w, oe_w;
  wire dout_w;
  int err_total = 0;
  int checks = 0;
  logic [63:0] g;
  logic s;
  assign dout_w = oe_w ? out_w : 1'bz; // Undriven wire floats.

  always #5 core_clk = ~core_clk;

  eeprom_port #(.WRITE_CYCLES(WRITE_CYCLES)) u_dut (.core_clk(core_clk),
    .nrst(nrst), .chip_select_pin(cs_w), .serial_clock_pin(sk_w),
    .serial_in_pin(di_w), .serial_out_pin(out_w), .serial_out_oe(oe_w));
  host_link_model u_host (.chip_select_pin(cs_w), .serial_clock_pin(sk_w),
    .serial_in_pin(di_w), .dout(dout_w));

  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
    u_host.xfer({37'h0, 1'b1, OP_WRITE, a, d}, 27, g);
  endtask : wr_word

  task automatic special(input logic [1:0] sub);
    u_host.xfer({53'h0, 1'b1, OP_SPECIAL, sub, 6'h0}, 11, g);
  endtask : special

  // Reads n words from address a into g.
  task automatic rd_words(input logic [7:0] a, input int n);
    u_host.xfer({53'h0, 1'b1, OP_READ, a} << (16 * n), 11 + 16 * n, g);
  endtask : rd_words

  task automatic status(input logic e);
    u_host.poll(s);
    check({15'h0, s}, {15'h0, e});
  endtask : status

  // A write before any unlock is ignored and shows no status.
  task automatic t_locked();
    wr_word(8'h10, 16'hA5C3);
    status(1'bz);
  endtask : t_locked

  // Fill, a write dropped while busy, then a wrapping read.
  task automatic t_fill();
    special(SUB_UNLOCK);
    u_host.xfer({37'h0, 1'b1, OP_SPECIAL, SUB_FILL, 6'h0, 16'h0F0F}, 27, g);
    status(1'b0);
    wr_word(8'h20, 16'h5555);
    repeat (WRITE_CYCLES + 20) @(posedge core_clk);
    rd_words(8'hFF, 2);
    check({15'h0, g[32]}, 16'h0000);
    check(g[31:16], 16'h0F0F);
    check(g[15:0], 16'h0F0F);
    rd_words(8'h20, 1);
    check(g[15:0], 16'h0F0F);
  endtask : t_fill

  // Leading zeros before the start bit, then write and read back.
  task automatic t_write();
    u_host.xfer({34'h0, 3'b000, 1'b1, OP_WRITE, 8'h3E, 16'hA5C3}, 30, g);
    status(1'b0);
    repeat (WRITE_CYCLES + 20) @(posedge core_clk);
    status(1'b1);
    rd_words(8'h3E, 2);
    check(g[31:16], 16'hA5C3);
    check(g[15:0], 16'h0F0F);
  endtask : t_write

  // Optional erase codes do nothing; a start bit ends the status.
  task automatic t_nop();
    u_host.xfer({53'h0, 1'b1, OP_ERASE, 8'h3E}, 11, g);
    special(SUB_CLEAR);
    status(1'bz);
    rd_words(8'h3E, 1);
    check(g[15:0], 16'hA5C3);
  endtask : t_nop

  // After locking, writes are ignored and reads still work.
  task automatic t_lock();
    special(SUB_LOCK);
    wr_word(8'h3E, 16'h1234);
    status(1'bz);
    rd_words(8'h3E, 1);
    check(g[15:0], 16'hA5C3);
  endtask : t_lock

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // Main sequence.
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_locked();
    t_fill();
    t_write();
    t_nop();
    t_lock();
    end_sim();
  end

  // Cuts a hang short well beyond the expected run time.
  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    end_sim();
  end
endmodule : test_serial_eeprom_command_port

bind eeprom_port eeprom_port_properties #(.WRITE_CYCLES(WRITE_CYCLES))
  u_props (.core_clk(core_clk), .nrst(nrst),
  .chip_select_pin(chip_select_pin), .serial_clock_pin(serial_clock_pin),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe));
